// [rtl/ltmc_map.vh]
`ifndef LTMC_MAP_VH
`define LTMC_MAP_VH

// Core clock and timing figures
`define LTMC_CLK_MHZ 125
`define LTMC_T_RESET_US 4000
`define LTMC_T_IGN_DB_US 160
// Cycle counts at the core clock, sized to the counters that load them
`define LTMC_RESET_CYC 20'd500000
`define LTMC_IGN_CYC 15'd20000
// Synchroniser reset: idle pin levels, so no false edge follows reset
`define LTMC_SYNC_RST 11'h056

// Register byte offsets
`define LTMC_OFS_FILT 12'h000
`define LTMC_OFS_TRIG 12'h004
`define LTMC_OFS_STAT 12'h008

// Reset values
`define LTMC_FILT_RST 32'h186a04e2
`define LTMC_TRIG_RST 32'h0000007d

// Filter and trigger register fields
`define LTMC_FILT_BUS_MSB 15
`define LTMC_FILT_BUS_LSB 0
`define LTMC_FILT_LOC_MSB 31
`define LTMC_FILT_LOC_LSB 16
`define LTMC_TRIG_MSB 15
`define LTMC_TRIG_LSB 0

// Status register fields
`define LTMC_ST_MODE_MSB 1
`define LTMC_ST_MODE_LSB 0
`define LTMC_ST_WREQ 2
`define LTMC_ST_WLOC 3
`define LTMC_ST_RST 4
`define LTMC_ST_RXEN 5
`define LTMC_ST_WDRUN 6

`endif

// [rtl/ltmc_mode_ctl.v]
`timescale 1ns/1ps
`include "ltmc_map.vh"

module ltmc_mode_ctl #(
   parameter [19:0] RESET_CYC = `LTMC_RESET_CYC,
   parameter [14:0] IGN_CYC = `LTMC_IGN_CYC
) (
   input wire clk,
   input wire nrst,
   input wire [11:0] paddr,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire mode_ctl_in,
   input wire txd_in,
   output wire txd_o,
   output wire txd_oe,
   input wire bus_level_in,
   input wire bus_prewake_threshold,
   input wire wake_sw_n,
   input wire ignition_sense_in,
   input wire watchdog_kick_n,
   input wire watchdog_mode_in,
   input wire vcc_undervoltage,
   input wire watchdog_fail,
   input wire reset_out_n_i,
   output wire reset_out_n_o,
   output wire reset_out_n_oe,
   output wire rxd_out,
   output wire bus_drive_dom,
   output wire bus_rx_en,
   output wire bus_term_en,
   output wire regulator_en,
   output wire ext_regulator_ctl,
   output wire watchdog_en,
   output wire watchdog_trigger
);

   localparam [1:0] MD_SAFE = 2'h0;
   localparam [1:0] MD_NORMAL = 2'h1;
   localparam [1:0] MD_SILENT = 2'h2;
   localparam [1:0] MD_SLEEP = 2'h3;
   // Synchroniser slots
   localparam I_EN = 0;
   localparam I_TXD = 1;
   localparam I_BUS = 2;
   localparam I_PRE = 3;
   localparam I_WK = 4;
   localparam I_IGN = 5;
   localparam I_KICK = 6;
   localparam I_WDM = 7;
   localparam I_UV = 8;
   localparam I_WDF = 9;
   localparam I_RPIN = 10;
   wire [10:0] pins;
   reg [10:0] sync1_r;
   reg [10:0] sync2_r;
   reg [10:0] prev_r;
   reg [1:0] mode_r;
   reg [19:0] rst_cnt_r;
   reg [15:0] bus_cnt_r;
   reg [15:0] wk_cnt_r;
   reg wk_arm_r;
   reg [14:0] ign_cnt_r;
   reg ign_arm_r;
   reg [15:0] kick_cnt_r;
   reg kick_arm_r;
   reg prewake_r;
   reg wake_req_r;
   reg wake_loc_r;
   reg [31:0] filt_r;
   reg [31:0] trig_r;
   reg [31:0] prdata_r;
   reg pready_r;
   reg pslverr_r;
   reg txd_o_r;
   reg txd_oe_r;
   reg rst_oe_r;
   reg rxd_r;
   reg drive_r;
   reg rx_en_r;
   reg term_r;
   reg reg_en_r;
   reg inh_r;
   reg wd_en_r;
   reg wd_trig_r;
   assign pins = {reset_out_n_i, watchdog_fail, vcc_undervoltage, watchdog_mode_in,
                  watchdog_kick_n, ignition_sense_in, wake_sw_n,
                  bus_prewake_threshold, bus_level_in, txd_in, mode_ctl_in};
   // Every pin crosses two flops; idle reset levels avoid a false edge
   always @(posedge clk) begin
      if (!nrst) begin
         sync1_r <= `LTMC_SYNC_RST;
         sync2_r <= `LTMC_SYNC_RST;
         prev_r <= `LTMC_SYNC_RST;
      end else begin
         sync1_r <= pins;
         sync2_r <= sync1_r;
         prev_r <= sync2_r;
      end
   end
   wire en_s = sync2_r[I_EN];
   wire txd_s = sync2_r[I_TXD];
   wire bus_s = sync2_r[I_BUS];
   wire en_fall = prev_r[I_EN] & ~en_s;
   wire en_rise = ~prev_r[I_EN] & en_s;
   wire bus_rise = ~prev_r[I_BUS] & bus_s;
   wire wk_fall = prev_r[I_WK] & ~sync2_r[I_WK];
   wire ign_rise = ~prev_r[I_IGN] & sync2_r[I_IGN];
   wire kick_fall = prev_r[I_KICK] & ~sync2_r[I_KICK];
   wire low_pwr = mode_r[1];
   wire blocked = (rst_cnt_r != 20'h00000);
   wire fault = sync2_r[I_UV] | sync2_r[I_WDF];
   wire rst_low = ~sync2_r[I_RPIN] | rst_oe_r;
   // Filter comparisons against software settings; ignition compares against the IGN_CYC parameter
   wire [15:0] bus_filt = filt_r[`LTMC_FILT_BUS_MSB:`LTMC_FILT_BUS_LSB];
   wire [15:0] loc_filt = filt_r[`LTMC_FILT_LOC_MSB:`LTMC_FILT_LOC_LSB];
   wire [15:0] trig_min = trig_r[`LTMC_TRIG_MSB:`LTMC_TRIG_LSB];
   wire wk_fire = wk_arm_r & ~sync2_r[I_WK] & (wk_cnt_r == loc_filt);
   wire ign_fire = ign_arm_r & sync2_r[I_IGN] & (ign_cnt_r == IGN_CYC);
   wire kick_fire = kick_arm_r & ~sync2_r[I_KICK] & (kick_cnt_r == trig_min);
   wire remote_ev = low_pwr & rx_en_r & bus_rise & (bus_cnt_r > bus_filt);
   wire local_ev = low_pwr & (wk_fire | ign_fire);
   // Reset delay; reloaded while faulted or while the regulator is off
   always @(posedge clk) begin
      if (!nrst) begin
         rst_cnt_r <= RESET_CYC;
      end else if (fault | (mode_r == MD_SLEEP)) begin
         rst_cnt_r <= RESET_CYC;
      end else if (blocked) begin
         rst_cnt_r <= rst_cnt_r - 20'h00001;
      end
   end
   // Bus dominant-time counter, saturating
   always @(posedge clk) begin
      if (!nrst || bus_s || !rx_en_r) begin
         bus_cnt_r <= 16'h0000;
      end else if (bus_cnt_r != 16'hffff) begin
         bus_cnt_r <= bus_cnt_r + 16'h0001;
      end
   end
   // Local switch: falling edge arms, low level must outlast filter
   always @(posedge clk) begin
      if (!nrst || sync2_r[I_WK] || wk_fire) begin
         wk_arm_r <= 1'b0;
         wk_cnt_r <= 16'h0000;
      end else if (wk_fall) begin
         wk_arm_r <= 1'b1;
         wk_cnt_r <= 16'h0000;
      end else if (wk_arm_r) begin
         wk_cnt_r <= wk_cnt_r + 16'h0001;
      end
   end
   // Ignition: only a rising edge arms, so a steady high never wakes
   always @(posedge clk) begin
      if (!nrst || !sync2_r[I_IGN] || ign_fire) begin
         ign_arm_r <= 1'b0;
         ign_cnt_r <= 15'h0000;
      end else if (ign_rise) begin
         ign_arm_r <= 1'b1;
         ign_cnt_r <= 15'h0000;
      end else if (ign_arm_r) begin
         ign_cnt_r <= ign_cnt_r + 15'h0001;
      end
   end
   // Watchdog kick: short glitches never count
   always @(posedge clk) begin
      if (!nrst || sync2_r[I_KICK] || kick_fire) begin
         kick_arm_r <= 1'b0;
         kick_cnt_r <= 16'h0000;
      end else if (kick_fall) begin
         kick_arm_r <= 1'b1;
         kick_cnt_r <= 16'h0000;
      end else if (kick_arm_r) begin
         kick_cnt_r <= kick_cnt_r + 16'h0001;
      end
   end

   // Pre-wake latch, held only while in a low-power mode
   always @(posedge clk) begin
      if (!nrst || !low_pwr) begin
         prewake_r <= 1'b0;
      end else if (sync2_r[I_PRE]) begin
         prewake_r <= 1'b1;
      end
   end

   // Wake flags; a new event beats the clear
   always @(posedge clk) begin
      if (!nrst) begin
         wake_req_r <= 1'b0;
         wake_loc_r <= 1'b0;
      end else if (remote_ev | local_ev) begin
         wake_req_r <= 1'b1;
         wake_loc_r <= local_ev;
      end else if ((mode_r == MD_NORMAL) && en_s) begin
         wake_req_r <= 1'b0;
         wake_loc_r <= 1'b0;
      end
   end

   // Mode sequencer
   always @(posedge clk) begin
      if (!nrst) begin
         mode_r <= MD_SAFE;
      end else begin
         case (mode_r)
            MD_SAFE: begin
               if (!blocked && !fault && en_s) begin
                  mode_r <= MD_NORMAL;
               end
            end
            MD_NORMAL: begin
               if (rst_low) begin
                  mode_r <= MD_SAFE;
               end else if (en_fall) begin
                  mode_r <= txd_s ? MD_SILENT : MD_SLEEP;
               end
            end
            MD_SILENT: begin
               if (rst_low || remote_ev || local_ev) begin
                  mode_r <= MD_SAFE;
               end else if (en_rise) begin
                  mode_r <= blocked ? MD_SAFE : MD_NORMAL;
               end
            end
            default: begin
               if (remote_ev || local_ev || en_rise) begin
                  mode_r <= MD_SAFE;
               end
            end
         endcase
      end
   end

   // Pin outputs, one flop each
   always @(posedge clk) begin
      if (!nrst) begin
         rxd_r <= 1'b1;
         drive_r <= 1'b0;
         rx_en_r <= 1'b0;
         term_r <= 1'b1;
         reg_en_r <= 1'b1;
         inh_r <= 1'b0;
         rst_oe_r <= 1'b1;
         txd_o_r <= 1'b1;
         txd_oe_r <= 1'b0;
         wd_en_r <= 1'b0;
         wd_trig_r <= 1'b0;
      end else begin
         case (mode_r)
            MD_NORMAL: rxd_r <= bus_s;
            MD_SAFE: rxd_r <= ~wake_req_r;
            MD_SILENT: rxd_r <= 1'b1;
            default: rxd_r <= 1'b0;
         endcase
         drive_r <= (mode_r == MD_NORMAL) & ~txd_s;
         rx_en_r <= (mode_r == MD_NORMAL) | prewake_r;
         term_r <= ~low_pwr | prewake_r;
         reg_en_r <= (mode_r != MD_SLEEP);
         inh_r <= ~low_pwr & ~sync2_r[I_UV];
         rst_oe_r <= fault | blocked | (mode_r == MD_SLEEP);
         txd_o_r <= ~wake_loc_r;
         txd_oe_r <= (mode_r == MD_SAFE) & wake_loc_r;
         wd_en_r <= ~low_pwr & ~sync2_r[I_WDM];
         wd_trig_r <= kick_fire & wd_en_r;
      end
   end

   // APB slave: ready in the cycle after setup, so no wait states
   wire setup = psel & ~penable;
   wire hit_filt = (paddr == `LTMC_OFS_FILT);
   wire hit_trig = (paddr == `LTMC_OFS_TRIG);
   wire hit_stat = (paddr == `LTMC_OFS_STAT);
   wire wr_go = psel & penable & pready_r & pwrite;
   reg [31:0] rd_mux;

   // Read decode; status shows live sequencer state
   always @* begin
      rd_mux = 32'h00000000;
      if (hit_filt) begin
         rd_mux = filt_r;
      end else if (hit_trig) begin
         rd_mux = trig_r;
      end else if (hit_stat) begin
         rd_mux[`LTMC_ST_MODE_MSB:`LTMC_ST_MODE_LSB] = mode_r;
         rd_mux[`LTMC_ST_WREQ] = wake_req_r;
         rd_mux[`LTMC_ST_WLOC] = wake_loc_r;
         rd_mux[`LTMC_ST_RST] = rst_oe_r;
         rd_mux[`LTMC_ST_RXEN] = rx_en_r;
         rd_mux[`LTMC_ST_WDRUN] = wd_en_r;
      end
   end

   always @(posedge clk) begin
      if (!nrst) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h00000000;
      end else begin
         pready_r <= setup;
         pslverr_r <= setup & ~(hit_filt | hit_trig | hit_stat);
         prdata_r <= (setup & ~pwrite) ? rd_mux : 32'h00000000;
      end
   end

   // Writes land on the completing edge; status writes are ignored
   always @(posedge clk) begin
      if (!nrst) begin
         filt_r <= `LTMC_FILT_RST;
         trig_r <= `LTMC_TRIG_RST;
      end else if (wr_go) begin
         if (hit_filt) begin
            filt_r <= pwdata;
         end else if (hit_trig) begin
            trig_r <= {16'h0000, pwdata[15:0]};
         end
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign txd_o = txd_o_r;
   assign txd_oe = txd_oe_r;
   assign reset_out_n_o = 1'b0;
   assign reset_out_n_oe = rst_oe_r;
   assign rxd_out = rxd_r;
   assign bus_drive_dom = drive_r;
   assign bus_rx_en = rx_en_r;
   assign bus_term_en = term_r;
   assign regulator_en = reg_en_r;
   assign ext_regulator_ctl = inh_r;
   assign watchdog_en = wd_en_r;
   assign watchdog_trigger = wd_trig_r;

endmodule // ltmc_mode_ctl

// [sim/ltmc_host.sv]
`timescale 1ns/1ps
// Host side pins: mode request, transmit data and watchdog kick
module ltmc_host (
   input wire clk,
   output logic mode_ctl_in,
   output logic txd_in,
   output logic watchdog_kick_n
);
   initial begin
      mode_ctl_in = 1'b0;
      txd_in = 1'b1;
      watchdog_kick_n = 1'b1;
   end
   // Transmit level moves with the mode edge, so it is steady across the select window
   task automatic set_mode(input logic m, input logic t);
      @(posedge clk);
      txd_in <= t;
      mode_ctl_in <= m;
   endtask
   // Kick held low for a whole number of cycles, then released
   task automatic kick(input int n);
      @(posedge clk);
      watchdog_kick_n <= 1'b0;
      repeat (n) @(posedge clk);
      watchdog_kick_n <= 1'b1;
   endtask
endmodule // ltmc_host

// [sim/ltmc_mode_ctl_asserts.sv]
`timescale 1ns/1ps
module ltmc_chk (
   input wire clk,
   input wire nrst,
   input wire [11:0] paddr,
   input wire psel,
   input wire penable,
   input wire pready,
   input wire pslverr,
   input wire bus_prewake_threshold,
   input wire watchdog_kick_n,
   input wire reset_out_n_oe,
   input wire bus_drive_dom,
   input wire bus_rx_en,
   input wire bus_term_en,
   input wire regulator_en,
   input wire ext_regulator_ctl,
   input wire rxd_out,
   input wire watchdog_en,
   input wire watchdog_trigger
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // Bus setup phase; pre-wake level held in Silent (no reset, no EXT_REGULATOR_CTL-like drive) or Sleep
   sequence setup_s; psel && !penable; endsequence
   sequence prewake_s;
      (bus_prewake_threshold && !ext_regulator_ctl && !reset_out_n_oe)[*6];
   endsequence
   sequence prewake_sleep_s;
      (bus_prewake_threshold && !regulator_en)[*6];
   endsequence
   a_apb_ready: assert property (setup_s |=> pready)
      else $error("no ready after setup");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_err_map: assert property (pready |->
      pslverr == !(paddr == 12'h000 || paddr == 12'h004 || paddr == 12'h008))
      else $error("error flag wrong for address");
   a_sleep_quiet: assert property (!regulator_en |-> !ext_regulator_ctl && !rxd_out && reset_out_n_oe)
      else $error("sleep outputs wrong");
   a_drive_norm: assert property (bus_drive_dom |-> regulator_en && bus_rx_en)
      else $error("bus driven outside normal");
   a_rst_hold: assert property ($rose(nrst) |-> reset_out_n_oe[*8])
      else $error("reset pin released early");
   a_trig_pulse: assert property (watchdog_trigger |-> watchdog_en ##1 !watchdog_trigger)
      else $error("trigger without watchdog or too long");
   a_kick_len: assert property (watchdog_trigger |-> !$past(watchdog_kick_n, 6))
      else $error("trigger without long kick");
   a_prewake_rx: assert property (prewake_s |-> bus_rx_en && bus_term_en)
      else $error("receiver not enabled on pre-wake");
   a_prewake_sleep: assert property (prewake_sleep_s |-> bus_rx_en && bus_term_en)
      else $error("receiver not enabled on pre-wake in sleep");
endmodule // ltmc_chk
bind ltmc_mode_ctl ltmc_chk u_chk (.clk, .nrst, .paddr, .psel, .penable, .pready, .pslverr,
   .bus_prewake_threshold, .watchdog_kick_n, .reset_out_n_oe, .bus_drive_dom, .bus_rx_en,
   .bus_term_en, .regulator_en, .ext_regulator_ctl, .rxd_out, .watchdog_en, .watchdog_trigger);

// [sim/testbench.sv]
`timescale 1ns/1ps
module testbench;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rnd = 32'ha5b7f8c9;
   logic bus = 1'b1, prew = 1'b0, sw_n = 1'b1, ign = 1'b0, wdm = 1'b0, uv = 1'b0, wdf = 1'b0;
   logic rst_oe, rxd, drv, regen, ext, wden, trig, txd_oe, rxen, term;
   wire mode_in, txd, kick_n;
   logic [63:0] exp_q[$];
   int err_total = 0, n_checks = 0, cyc = 0, trigs = 0;
   // Free-running clock, 8 ns period
   always #4 clk = ~clk;
   ltmc_host host (.clk(clk), .mode_ctl_in(mode_in), .txd_in(txd), .watchdog_kick_n(kick_n));
   // Short reset delay and debounce keep the run brief
   ltmc_mode_ctl #(.RESET_CYC(20'd20), .IGN_CYC(15'd10)) uut (.clk(clk), .nrst(nrst),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .mode_ctl_in(mode_in),
      .txd_in(txd), .txd_o(), .txd_oe(txd_oe), .bus_level_in(bus),
      .bus_prewake_threshold(prew), .wake_sw_n(sw_n), .ignition_sense_in(ign),
      .watchdog_kick_n(kick_n), .watchdog_mode_in(wdm), .vcc_undervoltage(uv),
      .watchdog_fail(wdf), .reset_out_n_i(!rst_oe), .reset_out_n_o(),
      .reset_out_n_oe(rst_oe), .rxd_out(rxd), .bus_drive_dom(drv), .bus_rx_en(rxen),
      .bus_term_en(term), .regulator_en(regen), .ext_regulator_ctl(ext), .watchdog_en(wden),
      .watchdog_trigger(trig));
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // One bus transfer; a read leaves its masked expectation in the queue
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, m);
      if (!w) exp_q.push_back({m, d});
      @(posedge clk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Request stands until ready is seen at a rising edge; the hang guard ends a stall
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic st(input logic [31:0] m, e);
      apb(12'h008, 1'b0, e, m);
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Read answers taken at the completing rising edge, as the master does
   always @(posedge clk) begin
      if (pready === 1'b1 && psel && penable && !pwrite && exp_q.size() != 0) begin
         chk(prdata & exp_q[0][63:32], exp_q[0][31:0]);
         void'(exp_q.pop_front());
      end
   end
   // Trigger count and hang guard
   always @(posedge clk) begin
      cyc++;
      if (trig === 1'b1) trigs++;
      if (cyc == 6000) begin
         err_total++;
         results();
      end
   end
   initial begin
      wt(4);
      nrst <= 1'b1;
      wt(2);
      chk(rst_oe, 1'b1);
      apb(12'h000, 1'b0, 32'h186a04e2, '1);
      apb(12'h004, 1'b0, 32'h0000007d, '1);
      apb(12'h00c, 1'b0, 32'h0, '1);
      rnd = xs(rnd);
      apb(12'h008, 1'b1, rnd, 32'h0);
      apb(12'h000, 1'b1, 32'h00080008, 32'h0);
      apb(12'h004, 1'b1, 32'h00000008, 32'h0);
      st(32'h3, 32'h0);
      host.set_mode(1'b1, 1'b1);
      wt(8);
      st(32'h3, 32'h1);
      chk({rst_oe, regen, ext}, 3'b011);
      bus <= 1'b0;
      wt(6);
      chk(rxd, 1'b0);
      bus <= 1'b1;
      host.set_mode(1'b1, 1'b0);
      wt(6);
      chk({rxd, drv}, 2'b11);
      host.set_mode(1'b1, 1'b1);
      $display("test normal done");
      host.kick(4);
      host.kick(12);
      wt(8);
      chk(trigs, 1);
      wdm <= 1'b1;
      host.kick(12);
      wt(8);
      chk({wden, trigs[1:0]}, 3'b001);
      wdm <= 1'b0;
      $display("test watchdog done");
      host.set_mode(1'b0, 1'b1);
      wt(8);
      st(32'h3, 32'h2);
      chk({regen, ext, wden, rxd, rxen, term}, 6'b100100);
      prew <= 1'b1;
      wt(6);
      chk({rxen, term}, 2'b11);
      bus <= 1'b0;
      wt(14);
      bus <= 1'b1;
      prew <= 1'b0;
      wt(8);
      chk({rxd, ext, txd_oe}, 3'b010);
      st(32'hf, 32'h4);
      host.set_mode(1'b1, 1'b1);
      wt(8);
      st(32'hf, 32'h1);
      $display("test remote wake done");
      rnd = xs(rnd);
      bus <= rnd[0];
      host.set_mode(1'b0, 1'b0);
      wt(8);
      bus <= 1'b1;
      st(32'h3, 32'h3);
      chk({regen, rxd, rst_oe}, 3'b001);
      prew <= 1'b1;
      wt(6);
      chk({rxen, term}, 2'b11);
      prew <= 1'b0;
      sw_n <= 1'b0;
      wt(14);
      sw_n <= 1'b1;
      chk({txd_oe, rxd}, 2'b10);
      st(32'hf, 32'hc);
      host.set_mode(1'b1, 1'b1);
      wt(40);
      st(32'hf, 32'h1);
      $display("test local wake done");
      host.set_mode(1'b0, 1'b0);
      wt(8);
      ign <= 1'b1;
      wt(5);
      ign <= 1'b0;
      wt(8);
      st(32'h3, 32'h3);
      ign <= 1'b1;
      wt(16);
      st(32'hf, 32'hc);
      ign <= 1'b0;
      host.set_mode(1'b1, 1'b1);
      wt(40);
      host.set_mode(1'b0, 1'b0);
      wt(8);
      host.set_mode(1'b1, 1'b1);
      wt(4);
      st(32'h3, 32'h0);
      wt(40);
      st(32'h3, 32'h1);
      $display("test ignition done");
      uv <= 1'b1;
      wt(8);
      chk({rst_oe, ext}, 2'b10);
      st(32'h3, 32'h0);
      uv <= 1'b0;
      wt(40);
      st(32'h3, 32'h1);
      wdf <= 1'b1;
      wt(8);
      chk({rst_oe, ext}, 2'b11);
      st(32'h3, 32'h0);
      wdf <= 1'b0;
      wt(40);
      st(32'h3, 32'h1);
      $display("test undervoltage done");
      wt(4);
      results();
   end
endmodule // testbench
